// ---- rtl/plfl_params.svh ----
// Timing counts, field values and sizes of the power-line frame link host
`ifndef PLFL_PARAMS_SVH
`define PLFL_PARAMS_SVH
`define PLFL_CLK_HZ       100000000
`define PLFL_CLK_NS       10
`define PLFL_BAUD         1200
`define PLFL_OVS          16
`define PLFL_CHAR_BITS    11
`define PLFL_LAST_BIT     4'hA
`define PLFL_MID_SAMPLE   4'h7
`define PLFL_PREAMBLE     8'hFF
`define PLFL_HEADER       8'hAA
`define PLFL_TICK_NS      555560
`define PLFL_BUF_BYTES    16
`define PLFL_TX_FIXED     5'h06
`define PLFL_RX_FIXED     5'h04
`define PLFL_MAX_DATA     4'h9
`define PLFL_ACCESS_TICKS 4'h4
`define PLFL_FIFO_DEPTH   8
`define PLFL_BAUD_DIV     (`PLFL_CLK_HZ / (`PLFL_BAUD * `PLFL_OVS))
`define PLFL_TICK_CYCLES  (`PLFL_TICK_NS / `PLFL_CLK_NS)
`endif

// ---- rtl/plfl_pkg.sv ----
// Types of the power-line frame link host
package plfl_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} plfl_tx_state_t;
    typedef enum logic {RX_HUNT, RX_FIELDS} plfl_rx_state_t;
endpackage : plfl_pkg

// ---- rtl/plfl_fifo.sv ----
// Data FIFO with valid and ready on both sides
`timescale 1ns/1ps
module plfl_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem[rd_q];

    always_comb
    begin
        push  = i_in_valid && o_in_ready;
        pop   = o_out_valid && i_out_ready;
        wr_d  = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d  = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_q] <= i_in_data;
        end
    end
endmodule : plfl_fifo

// ---- rtl/plfl_host.sv ----
// Host frame engine driving a half-duplex power-line FSK modem
// How it works
// - Each character: start, eight data, odd parity, stop; eleven bits.
// - Serial characters run at 1200 baud.
// - Receiver checks odd parity per byte and flags errors on its own.
// - Frame order: preamble, header, house, control, source, dest, data, checksum.
// - First field is preamble FFh, training the demodulator.
// - Second field is header AAh.
// - Received frames with a foreign house address are dropped.
// - Received checksum is verified; mismatch flags the frame erroneous.
// - Writing the checksum into the transmit buffer starts sending.
// - Transmit-buffer-empty after each byte but the checksum loads the next one.
// - While hunting, each received byte is compared with the compare value.
// - A match raises header-match and following bytes become frame fields.
// - Each byte completed in receive direction raises a receive-byte event; only bytes after a header match are stored.
// - Transmit and receive frame buffers hold sixteen bytes each.
// - Each timer tick updates access timing and strobes the modem watchdog.
// - Three outputs go to the modem: serial data, direction select and watchdog strobe.
// - Direction low selects transmit, high selects receive.
// - Watchdog falling edges at least 800us apart, at most 1.5s.
// - Each bit spans sixteen oversampling periods.
`timescale 1ns/1ps
`include "plfl_params.svh"
module plfl_host #(
    parameter int BAUD_DIV    = `PLFL_BAUD_DIV,
    parameter int TICK_CYCLES = `PLFL_TICK_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_house_addr,
    input  wire logic [7:0] i_hdr_cmp,
    input  wire logic [7:0] i_link_ctrl,
    input  wire logic [7:0] i_src_addr,
    input  wire logic [7:0] i_dst_addr,
    input  wire logic [3:0] i_tx_len,
    input  wire logic       i_tx_start,
    output logic            o_tx_busy,
    output logic            o_tx_done,
    input  wire logic       i_data_valid,
    input  wire logic [7:0] i_data,
    output logic            o_data_ready,
    input  wire logic [3:0] i_rx_len,
    output logic            o_rx_done,
    output logic            o_rx_err,
    input  wire logic [3:0] i_rx_rd_addr,
    output logic [7:0]      o_rx_rd_data,
    output logic            o_rx_byte_event,
    output logic [7:0]      o_rx_byte,
    output logic            o_parity_err,
    output logic            o_header_match_event,
    output logic            o_tx_buffer_empty_event,
    output logic            o_carrier_event,
    output logic            o_access_ok,
    input  wire logic       i_carrier_sense_n,
    input  wire logic       i_modem_reset_out,
    input  wire logic       i_rxd,
    output logic            o_txd,
    output logic            o_dir_rx,
    output logic            o_modem_watchdog_strobe
);
    function automatic logic odd_par(input logic [7:0] b);
        odd_par = ~^b;
    endfunction : odd_par

    function automatic logic [7:0] sum8(input logic [7:0] a, input logic [7:0] b);
        sum8 = a + b;
    endfunction : sum8

    function automatic logic [3:0] clamp_len(input logic [3:0] l);
        clamp_len = (l > `PLFL_MAX_DATA) ? `PLFL_MAX_DATA : l;
    endfunction : clamp_len

    // Baud and tick dividers, carrier and access timing
    logic [12:0] div_q, div_d;
    logic [16:0] tick_q, tick_d;
    logic        ovs_en, tick;
    logic        wd_q, wd_d, cs_q, cs_d, cev_q, cev_d;
    logic [3:0]  acc_q, acc_d;

    always_comb
    begin
        ovs_en = (div_q == 13'(BAUD_DIV - 1));
        div_d  = ovs_en ? '0 : div_q + 1'b1;
        tick   = (tick_q == 17'(TICK_CYCLES - 1));
        tick_d = tick ? '0 : tick_q + 1'b1;
        // Toggling per tick keeps falling edges two ticks apart, above 800us
        wd_d   = tick ? ~wd_q : wd_q;
        cs_d   = i_carrier_sense_n;
        cev_d  = cs_q && !i_carrier_sense_n;
        acc_d  = acc_q;
        if (!i_carrier_sense_n)
        begin
            acc_d = '0;
        end
        else if (tick && acc_q != `PLFL_ACCESS_TICKS)
        begin
            acc_d = acc_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_q  <= '0;
            tick_q <= '0;
            wd_q   <= 1'b1;
            cs_q   <= 1'b1;
            cev_q  <= 1'b0;
            acc_q  <= '0;
        end
        else
        begin
            div_q  <= div_d;
            tick_q <= tick_d;
            wd_q   <= wd_d;
            cs_q   <= cs_d;
            cev_q  <= cev_d;
            acc_q  <= acc_d;
        end
    end

    assign o_modem_watchdog_strobe = wd_q;
    assign o_carrier_event         = cev_q;
    assign o_access_ok             = (acc_q == `PLFL_ACCESS_TICKS);

    // Serial transmitter
    logic        utx_busy_q, utx_busy_d, utx_load, tbe_q, tbe_d;
    logic [10:0] utx_sh_q, utx_sh_d;
    logic [3:0]  utx_bit_q, utx_bit_d, utx_ovs_q, utx_ovs_d;
    logic [7:0]  utx_byte;

    always_comb
    begin
        utx_busy_d = utx_busy_q;
        utx_sh_d   = utx_sh_q;
        utx_bit_d  = utx_bit_q;
        utx_ovs_d  = utx_ovs_q;
        tbe_d      = 1'b0;
        if (utx_load)
        begin
            utx_busy_d = 1'b1;
            utx_sh_d   = {1'b1, odd_par(utx_byte), utx_byte, 1'b0};
            utx_bit_d  = '0;
            utx_ovs_d  = '0;
        end
        else if (utx_busy_q && ovs_en)
        begin
            utx_ovs_d = utx_ovs_q + 1'b1;
            if (utx_ovs_q == 4'hF)
            begin
                utx_sh_d  = {1'b1, utx_sh_q[10:1]};
                utx_bit_d = utx_bit_q + 1'b1;
                if (utx_bit_q == `PLFL_LAST_BIT)
                begin
                    utx_busy_d = 1'b0;
                    tbe_d      = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            utx_busy_q <= 1'b0;
            utx_sh_q   <= 11'h7FF;
            utx_bit_q  <= '0;
            utx_ovs_q  <= '0;
            tbe_q      <= 1'b0;
        end
        else
        begin
            utx_busy_q <= utx_busy_d;
            utx_sh_q   <= utx_sh_d;
            utx_bit_q  <= utx_bit_d;
            utx_ovs_q  <= utx_ovs_d;
            tbe_q      <= tbe_d;
        end
    end

    assign o_txd                   = utx_sh_q[0];
    assign o_tx_buffer_empty_event = tbe_q;

    // Serial receiver, sampled mid-bit at the oversampling rate
    logic        urx_act_q, urx_act_d, rxb_q, rxb_d, perr_q, perr_d;
    logic [10:0] urx_sh_q, urx_sh_d;
    logic [3:0]  urx_bit_q, urx_bit_d, urx_ovs_q, urx_ovs_d;
    logic [7:0]  rxbyte_q, rxbyte_d;

    always_comb
    begin
        urx_act_d = urx_act_q;
        urx_sh_d  = urx_sh_q;
        urx_bit_d = urx_bit_q;
        urx_ovs_d = urx_ovs_q;
        rxb_d     = 1'b0;
        perr_d    = 1'b0;
        rxbyte_d  = rxbyte_q;
        if (ovs_en)
        begin
            if (!urx_act_q)
            begin
                if (!i_rxd)
                begin
                    urx_act_d = 1'b1;
                    urx_bit_d = '0;
                    urx_ovs_d = '0;
                end
            end
            else
            begin
                urx_ovs_d = urx_ovs_q + 1'b1;
                if (urx_ovs_q == `PLFL_MID_SAMPLE)
                begin
                    urx_sh_d  = {i_rxd, urx_sh_q[10:1]};
                    urx_bit_d = urx_bit_q + 1'b1;
                    if (urx_bit_q == '0 && i_rxd)
                    begin
                        urx_act_d = 1'b0; // Glitch, not a start bit
                    end
                    else if (urx_bit_q == `PLFL_LAST_BIT)
                    begin
                        urx_act_d = 1'b0;
                        // Deaf while transmitting: the line echoes our own bytes
                        rxb_d     = o_dir_rx;
                        rxbyte_d  = urx_sh_q[9:2];
                        perr_d    = o_dir_rx && ((urx_sh_q[10] != odd_par(urx_sh_q[9:2]))
                                    || !i_rxd);
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            urx_act_q <= 1'b0;
            urx_sh_q  <= '0;
            urx_bit_q <= '0;
            urx_ovs_q <= '0;
            rxb_q     <= 1'b0;
            perr_q    <= 1'b0;
            rxbyte_q  <= '0;
        end
        else
        begin
            urx_act_q <= urx_act_d;
            urx_sh_q  <= urx_sh_d;
            urx_bit_q <= urx_bit_d;
            urx_ovs_q <= urx_ovs_d;
            rxb_q     <= rxb_d;
            perr_q    <= perr_d;
            rxbyte_q  <= rxbyte_d;
        end
    end

    assign o_rx_byte_event = rxb_q;
    assign o_rx_byte       = rxbyte_q;
    assign o_parity_err    = perr_q;

    // Transmit framer fed from the data FIFO
    plfl_pkg::plfl_tx_state_t txs_q, txs_d;
    logic [7:0] txbuf [`PLFL_BUF_BYTES];
    logic [4:0] tidx_q, tidx_d, tlast_q, tlast_d;
    logic [3:0] tlen_q, tlen_d;
    logic [7:0] tsum_q, tsum_d, twr_data;
    logic       twr, fifo_valid, fifo_pop, dir_q, dir_d, tdone_q, tdone_d;
    logic [3:0] twr_addr;
    logic [7:0] fifo_data;

    plfl_fifo #(
        .W     (8),
        .DEPTH (`PLFL_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_data_valid),
        .i_in_data   (i_data),
        .o_in_ready  (o_data_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (fifo_pop)
    );

    always_comb
    begin
        txs_d    = txs_q;
        tidx_d   = tidx_q;
        tlast_d  = tlast_q;
        tlen_d   = tlen_q;
        tsum_d   = tsum_q;
        dir_d    = dir_q;
        tdone_d  = 1'b0;
        twr      = 1'b0;
        twr_addr = tidx_q[3:0];
        twr_data = fifo_data;
        fifo_pop = 1'b0;
        utx_load = 1'b0;
        utx_byte = txbuf[tidx_q[3:0]];
        case (txs_q)
            plfl_pkg::TX_IDLE:
            begin
                if (i_tx_start && o_access_ok && !i_modem_reset_out)
                begin
                    txs_d  = plfl_pkg::TX_LOAD;
                    tidx_d = `PLFL_TX_FIXED;
                    tlen_d = clamp_len(i_tx_len);
                    tsum_d = sum8(sum8(i_house_addr, i_link_ctrl),
                                  sum8(i_src_addr, i_dst_addr));
                end
            end
            plfl_pkg::TX_LOAD:
            begin
                if (tidx_q == `PLFL_TX_FIXED + 5'(tlen_q))
                begin
                    twr      = 1'b1;
                    twr_data = tsum_q;
                    tlast_d  = tidx_q;
                    tidx_d   = '0;
                    dir_d    = 1'b0;
                    txs_d    = plfl_pkg::TX_SEND;
                end
                else if (fifo_valid)
                begin
                    twr      = 1'b1;
                    fifo_pop = 1'b1;
                    tsum_d   = sum8(tsum_q, fifo_data);
                    tidx_d   = tidx_q + 1'b1;
                end
            end
            plfl_pkg::TX_SEND:
            begin
                // Next byte goes out once the empty event has retired the last
                if (!utx_busy_q && !tbe_q)
                begin
                    if (tidx_q > tlast_q)
                    begin
                        dir_d   = 1'b1;
                        tdone_d = 1'b1;
                        txs_d   = plfl_pkg::TX_IDLE;
                    end
                    else
                    begin
                        utx_load = 1'b1;
                        tidx_d   = tidx_q + 1'b1;
                    end
                end
            end
            default:
            begin
                txs_d = plfl_pkg::TX_IDLE;
                dir_d = 1'b1;
            end
        endcase
        if (i_modem_reset_out && txs_q != plfl_pkg::TX_IDLE)
        begin
            txs_d = plfl_pkg::TX_IDLE;
            dir_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            txs_q   <= plfl_pkg::TX_IDLE;
            tidx_q  <= '0;
            tlast_q <= '0;
            tlen_q  <= '0;
            tsum_q  <= '0;
            dir_q   <= 1'b1;
            tdone_q <= 1'b0;
        end
        else
        begin
            txs_q   <= txs_d;
            tidx_q  <= tidx_d;
            tlast_q <= tlast_d;
            tlen_q  <= tlen_d;
            tsum_q  <= tsum_d;
            dir_q   <= dir_d;
            tdone_q <= tdone_d;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (txs_q == plfl_pkg::TX_IDLE && txs_d == plfl_pkg::TX_LOAD)
        begin
            txbuf[0] <= `PLFL_PREAMBLE;
            txbuf[1] <= `PLFL_HEADER;
            txbuf[2] <= i_house_addr;
            txbuf[3] <= i_link_ctrl;
            txbuf[4] <= i_src_addr;
            txbuf[5] <= i_dst_addr;
        end
        else if (twr)
        begin
            txbuf[twr_addr] <= twr_data;
        end
    end

    assign o_dir_rx  = dir_q;
    assign o_tx_busy = (txs_q != plfl_pkg::TX_IDLE);
    assign o_tx_done = tdone_q;

    // Receive framer
    plfl_pkg::plfl_rx_state_t rxs_q, rxs_d;
    logic [7:0] rxbuf [`PLFL_BUF_BYTES];
    logic [4:0] rcnt_q, rcnt_d;
    logic [3:0] rlen_q, rlen_d;
    logic [7:0] rsum_q, rsum_d;
    logic       rerr_q, rerr_d, hok_q, hok_d, hm_q, hm_d, rdone_q, rdone_d, rerro_q, rerro_d;

    always_comb
    begin
        rxs_d   = rxs_q;
        rcnt_d  = rcnt_q;
        rlen_d  = rlen_q;
        rsum_d  = rsum_q;
        rerr_d  = rerr_q;
        hok_d   = hok_q;
        hm_d    = 1'b0;
        rdone_d = 1'b0;
        rerro_d = rerro_q;
        case (rxs_q)
            plfl_pkg::RX_HUNT:
            begin
                if (rxb_q && rxbyte_q == i_hdr_cmp)
                begin
                    hm_d   = 1'b1;
                    rxs_d  = plfl_pkg::RX_FIELDS;
                    rcnt_d = '0;
                    rsum_d = '0;
                    rerr_d = 1'b0;
                    rlen_d = clamp_len(i_rx_len);
                end
            end
            plfl_pkg::RX_FIELDS:
            begin
                if (rxb_q)
                begin
                    rcnt_d = rcnt_q + 1'b1;
                    rerr_d = rerr_q || perr_q;
                    if (rcnt_q == '0)
                    begin
                        hok_d = (rxbyte_q == i_house_addr);
                    end
                    if (rcnt_q == `PLFL_RX_FIXED + 5'(rlen_q))
                    begin
                        rxs_d   = plfl_pkg::RX_HUNT;
                        rdone_d = hok_q;
                        rerro_d = rerr_q || perr_q || (rsum_q != rxbyte_q);
                    end
                    else
                    begin
                        rsum_d = sum8(rsum_q, rxbyte_q);
                    end
                end
            end
            default:
            begin
                rxs_d = plfl_pkg::RX_HUNT;
            end
        endcase
        if (!o_dir_rx || i_modem_reset_out)
        begin
            rxs_d = plfl_pkg::RX_HUNT;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rxs_q   <= plfl_pkg::RX_HUNT;
            rcnt_q  <= '0;
            rlen_q  <= '0;
            rsum_q  <= '0;
            rerr_q  <= 1'b0;
            hok_q   <= 1'b0;
            hm_q    <= 1'b0;
            rdone_q <= 1'b0;
            rerro_q <= 1'b0;
        end
        else
        begin
            rxs_q   <= rxs_d;
            rcnt_q  <= rcnt_d;
            rlen_q  <= rlen_d;
            rsum_q  <= rsum_d;
            rerr_q  <= rerr_d;
            hok_q   <= hok_d;
            hm_q    <= hm_d;
            rdone_q <= rdone_d;
            rerro_q <= rerro_d;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (rxs_q == plfl_pkg::RX_FIELDS && rxb_q)
        begin
            rxbuf[rcnt_q[3:0]] <= rxbyte_q;
        end
    end

    assign o_rx_rd_data         = rxbuf[i_rx_rd_addr];
    assign o_header_match_event = hm_q;
    assign o_rx_done            = rdone_q;
    assign o_rx_err             = rerro_q;

    sequence carrier_fall_s;
        cs_q ##0 !i_carrier_sense_n;
    endsequence

    sequence header_seen_s;
        rxb_q && rxs_q == plfl_pkg::RX_HUNT && rxbyte_q == i_hdr_cmp && o_dir_rx;
    endsequence

    char_format_a: assert property (@(posedge i_clk) disable iff (i_rst)
        utx_load |=> !utx_sh_q[0] && utx_sh_q[10] && (^utx_sh_q[9:1]))
        else $error("character framing wrong");
    preamble_first_a: assert property (@(posedge i_clk) disable iff (i_rst)
        utx_load && tidx_q == '0 |-> utx_byte == `PLFL_PREAMBLE)
        else $error("first byte is not preamble");
    header_second_a: assert property (@(posedge i_clk) disable iff (i_rst)
        utx_load && tidx_q == 5'h01 |-> utx_byte == `PLFL_HEADER)
        else $error("second byte is not header");
    dir_transmit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        utx_busy_q |-> !o_dir_rx)
        else $error("sending while modem in receive");
    header_match_a: assert property (@(posedge i_clk) disable iff (i_rst)
        header_seen_s |=> o_header_match_event ##1 rxs_q == plfl_pkg::RX_FIELDS)
        else $error("header match missed");
    carrier_event_a: assert property (@(posedge i_clk) disable iff (i_rst)
        carrier_fall_s |=> o_carrier_event ##1 !o_carrier_event)
        else $error("carrier event wrong");
    watchdog_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tick |=> o_modem_watchdog_strobe != $past(o_modem_watchdog_strobe))
        else $error("watchdog not strobed on tick");
    empty_next_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tbe_q && txs_q == plfl_pkg::TX_SEND && !i_modem_reset_out
        |=> utx_load || tdone_d)
        else $error("no next byte after empty");
endmodule : plfl_host

// ---- sim/plfl_modem.sv ----
// Modem stand-in: decodes host characters, sources characters and carrier
`timescale 1ns/1ps
module plfl_modem #(
    parameter int BIT = 64
) (
    input  wire logic i_clk,
    input  wire logic i_txd,
    input  wire logic i_dir_rx,
    output logic      o_rxd,
    output logic      o_cs_n
);
    logic [7:0] cap_q[$];
    logic [9:0] sh;
    initial
    begin
        o_rxd = 1'b1;
        o_cs_n = 1'b1;
    end
    // Only characters sent in transmit mode with good framing are kept
    always
    begin
        @(negedge i_txd);
        repeat (BIT / 2) @(posedge i_clk);
        for (int i = 0; i < 10; i++)
        begin
            repeat (BIT) @(posedge i_clk);
            sh[i] = i_txd;
        end
        if (!i_dir_rx && sh[9] && ^sh[8:0])
            cap_q.push_back(sh[7:0]);
    end
    // One character to the host; a false flag spoils the parity bit
    task automatic send(input logic [7:0] b, input logic pok);
        logic [10:0] f;
        f = {1'b1, (~^b) ^ !pok, b, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            @(negedge i_clk);
            o_rxd = f[i];
            repeat (BIT - 1) @(negedge i_clk);
        end
    endtask : send
    // Short carrier burst on the active-low sense line
    task automatic carrier();
        @(negedge i_clk);
        o_cs_n = 1'b0;
        repeat (8) @(negedge i_clk);
        o_cs_n = 1'b1;
        repeat (2) @(negedge i_clk);
    endtask : carrier
endmodule : plfl_modem

// ---- sim/tb.sv ----
// Bench of the frame link host against the modem stand-in
`timescale 1ns/1ps
module tb;
    logic       clk, rst, start, dv, cs_n, rxd, wd_q;
    logic       busy, done, rdy, rdone, rerr, bev, perr, hev, tbe, cev, aok, txd, dir, wd;
    logic [7:0] din, rdat, rbyte, hs, lc, sa, da, rs, exp_q[$];
    logic [3:0] raddr, tl, rl;
    int         err_count, check_count, n_hev, n_done, n_perr, n_tbe, n_cev, n_wdf, n_bev;
    plfl_host #(.BAUD_DIV(4), .TICK_CYCLES(50)) dut_u (
        .i_clk(clk), .i_rst(rst), .i_house_addr(hs), .i_hdr_cmp(8'hAA),
        .i_link_ctrl(lc), .i_src_addr(sa), .i_dst_addr(da), .i_tx_len(tl),
        .i_tx_start(start), .o_tx_busy(busy), .o_tx_done(done), .i_data_valid(dv),
        .i_data(din), .o_data_ready(rdy), .i_rx_len(rl), .o_rx_done(rdone),
        .o_rx_err(rerr), .i_rx_rd_addr(raddr), .o_rx_rd_data(rdat),
        .o_rx_byte_event(bev), .o_rx_byte(rbyte), .o_parity_err(perr),
        .o_header_match_event(hev), .o_tx_buffer_empty_event(tbe),
        .o_carrier_event(cev), .o_access_ok(aok), .i_carrier_sense_n(cs_n),
        .i_modem_reset_out(1'b0), .i_rxd(rxd), .o_txd(txd), .o_dir_rx(dir),
        .o_modem_watchdog_strobe(wd));
    plfl_modem #(.BIT(64)) mdm_u (
        .i_clk(clk), .i_txd(txd), .i_dir_rx(dir), .o_rxd(rxd), .o_cs_n(cs_n));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulses are counted so no scenario can miss a one-cycle event
    always @(posedge clk)
    begin
        wd_q <= wd;
        n_hev += (hev === 1'b1);
        n_done += (rdone === 1'b1);
        n_perr += (perr === 1'b1);
        n_tbe += (tbe === 1'b1);
        n_cev += (cev === 1'b1);
        n_bev += (bev === 1'b1);
        n_wdf += (wd_q === 1'b1 && wd === 1'b0);
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic t_tx;
        logic [7:0] s;
        s = hs + lc + sa + da;
        exp_q = '{8'hFF, 8'hAA, hs, lc, sa, da};
        for (int i = 0; i <= 8; i++)
        begin
            din = 8'(i * 17);
            dv = 1'b1;
            @(negedge clk);
            exp_q.push_back(din);
            s += din;
        end
        chk("fifo_full", {7'h0, rdy}, 8'h0);
        dv = 1'b0;
        s -= din;
        void'(exp_q.pop_back());
        exp_q.push_back(s);
        for (int i = 0; i < 4000 && aok !== 1'b1; i++) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        chk("busy", {7'h0, busy}, 8'h1);
        repeat (1000) @(negedge clk);
        chk("dir_tx", {7'h0, dir}, 8'h0);
        for (int i = 0; i < 12000 && done !== 1'b1; i++) @(negedge clk);
        chk("dir_rx", {7'h0, dir}, 8'h1);
        chk("tbe_cnt", 8'(n_tbe), 8'h0F);
        chk("chars", 8'(mdm_u.cap_q.size()), 8'h0F);
        for (int i = 0; i < 15; i++)
            chk("tx_byte", mdm_u.cap_q[i], exp_q[i]);
    endtask : t_tx
    task automatic rx_frame(input logic [7:0] h, input logic [7:0] bad, input logic pok);
        rs = h + 8'h3A + 8'h12 + 8'h34 + 8'h77 + bad;
        exp_q = '{8'h55, 8'hAA, h, 8'h3A, 8'h12, 8'h34, 8'h77, rs};
        foreach (exp_q[i])
            mdm_u.send(exp_q[i], pok || i != 6);
        repeat (8) @(negedge clk);
    endtask : rx_frame
    task automatic t_rx_good;
        int h0;
        int d0;
        int b0;
        h0 = n_hev;
        d0 = n_done;
        b0 = n_bev;
        rx_frame(hs, 8'h00, 1'b1);
        chk("rx_events", 8'(n_bev - b0), 8'h08);
        chk("hdr_match", 8'(n_hev - h0), 8'd1);
        chk("rx_done", 8'(n_done - d0), 8'd1);
        chk("rx_err", {7'h0, rerr}, 8'h0);
        chk("rx_byte", rbyte, rs);
        for (int i = 0; i < 5; i++)
        begin
            @(negedge clk);
            raddr = 4'(i);
            #1;
            chk("rx_buf", rdat, exp_q[i + 2]);
        end
    endtask : t_rx_good
    task automatic t_rx_bad_sum;
        int d0;
        d0 = n_done;
        rx_frame(hs, 8'h01, 1'b1);
        chk("bad_done", 8'(n_done - d0), 8'd1);
        chk("bad_err", {7'h0, rerr}, 8'h1);
    endtask : t_rx_bad_sum
    task automatic t_rx_foreign;
        int d0;
        int p0;
        d0 = n_done;
        p0 = n_perr;
        rx_frame(~hs, 8'h00, 1'b0);
        chk("foreign", 8'(n_done - d0), 8'd0);
        chk("par_err", 8'(n_perr - p0), 8'd1);
    endtask : t_rx_foreign
    task automatic t_modem_pins;
        int w0;
        int c0;
        w0 = n_wdf;
        repeat (400) @(negedge clk);
        chk("wd_falls", 8'(n_wdf - w0), 8'd4);
        c0 = n_cev;
        mdm_u.carrier();
        chk("carrier", 8'(n_cev - c0), 8'd1);
        chk("access", {7'h0, aok}, 8'h0);
    endtask : t_modem_pins
    initial
    begin
        #400000;
        err_count++;
        tally_and_finish();
    end
    initial
    begin
        rst = 1'b1;
        start = 1'b0;
        dv = 1'b0;
        din = 8'h00;
        raddr = 4'h0;
        {hs, lc, sa, da} = 32'h5C3A1234;
        {tl, rl} = 8'h81;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk("rst_out", {3'h0, txd, dir, wd, busy, rdy}, 8'h1D);
        t_tx();
        t_rx_good();
        t_rx_bad_sum();
        t_rx_foreign();
        t_modem_pins();
        tally_and_finish();
    end
endmodule : tb
